// >>> verilog/mrc_pkg.sv
// Package of constants and types for the motor run command logic
package mrc_pkg;
   // Clock rate and input recognition time
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned MIN_HOLD_MS = 10;
   localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * MIN_HOLD_MS;
   // Reference speed of the ramp definitions, r/min
   localparam logic [11:0] REF_SPEED_RPM = 12'hBB8;
   // Ramp time in tenths of a second
   localparam logic [7:0] RAMP_T_MIN = 8'h01;
   localparam logic [7:0] RAMP_T_MAX = 8'h96;
   localparam logic [7:0] RAMP_T_RST = 8'h01;
   // Tenth of a second in clock cycles
   localparam int unsigned TENTH_CYC = CLK_HZ / 10;
   // Torque limit, percent of rated
   localparam logic [7:0] TRQ_MAX_PCT = 8'hC8;
   // Speed offset limit, r/min
   localparam logic [11:0] OFFSET_MAX_RPM = 12'h5DC;
   localparam logic [12:0] SPEED_MAX = 13'h1FFF;
   // Select width and number of operation data sets
   localparam int unsigned SEL_W = 3;
   localparam int unsigned SETS = 8;

   // Command state of the motor
   typedef enum logic [1:0] {
      MRC_STOPPED,
      MRC_RUN,
      MRC_DECEL,
      MRC_INSTANT
   } mrc_state_t;

   // Source method of one data set value
   typedef enum logic [1:0] {
      MRC_SRC_DIGITAL,
      MRC_SRC_POT_ONE,
      MRC_SRC_POT_TWO,
      MRC_SRC_EXTERNAL
   } mrc_src_t;
endpackage : mrc_pkg

// >>> verilog/mrc_run_logic.sv
// Run, stop, ramp and torque limit command logic of the motor driver
`timescale 1ns/1ps
`default_nettype none

// Port units: ramp times in tenths of a second, clamped 1 to 150;
// a pot used as speed counts 16 r/min a step; a pot or the digital
// limit used as torque counts percent of rated torque.
// Method words hold two bits a set: digital, pot one, pot two and
// external analog, set 0 in the lowest bits.
// Latency: a terminal level reaches the state output three edges
// after it changes, two synchroniser flops and one decode flop.
// Limitation: there is no glitch filter; a short pulse on a
// terminal is taken as a real level, so the controller must hold
// each level for the recognition time.

module mrc_run_logic
   import mrc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Terminal inputs from the controller, asynchronous
   input wire logic run_request_input_i,
   input wire logic brake_release_input_i,
   input wire logic direction_input_i,
   input wire logic speed_select_bit0_i,
   input wire logic speed_select_bit1_i,
   input wire logic speed_select_bit2_i,
   input wire logic [2:0] torque_limit_enable_input_i,
   // Configuration, same clock domain
   input wire logic speed_select_bit2_assigned_i,
   input wire logic [2:0] torque_limit_assigned_i,
   input wire logic rotation_direction_cw_i,
   input wire logic [11:0] analog_offset_rpm_i,
   input wire logic [11:0] analog_speed_rpm_i,
   input wire logic [7:0] internal_pot_one_i,
   input wire logic [7:0] internal_pot_two_i,
   input wire logic [7:0] torque_limit_pct_i,
   input wire logic [95:0] set_speed_rpm_i,
   input wire logic [63:0] set_accel_digital_i,
   input wire logic [63:0] set_decel_digital_i,
   input wire logic [15:0] set_speed_src_i,
   input wire logic [15:0] set_torque_src_i,
   input wire logic [15:0] set_accel_src_i,
   input wire logic [15:0] set_decel_src_i,
   // Outputs
   output logic [12:0] command_speed_rpm_o,
   output logic shaft_cw_o,
   output logic [7:0] torque_cap_pct_o,
   output logic torque_peak_o,
   output logic [2:0] selected_set_o,
   output logic [1:0] motor_state_o,
   output logic operation_prohibited_flag_o
);

   // All state of the block in one record
   typedef struct packed {
      // Synchroniser flops of the terminals
      logic [1:0] run_s1;
      logic [1:0] run_s2;
      logic [1:0] dir_s;
      logic [2:0] sel_s1;
      logic [2:0] sel_s2;
      logic [2:0] tl_s1;
      logic [2:0] tl_s2;
      // Command state and ramp
      mrc_state_t state;
      logic [12:0] speed;
      logic [12:0] target;
      logic [31:0] tick_cnt;
      logic [2:0] sel;
      // Methods frozen while the motor turns
      logic [15:0] speed_src;
      logic [15:0] torque_src;
      logic [15:0] accel_src;
      logic [15:0] decel_src;
      // Output copies
      logic shaft_cw;
      logic [7:0] trq_cap;
      logic trq_peak;
      logic prohibited;
   } mrc_regs_t;

   mrc_regs_t r_q;
   mrc_regs_t r_d;

   // Clamp a raw ramp time to the legal span in tenths
   // A zero setting would step the ramp every cycle, so it reads as 0.1 s
   function automatic logic [7:0] clamp_time(input logic [7:0] t);
      if (t < RAMP_T_MIN) begin
         return RAMP_T_MIN;
      end else if (t > RAMP_T_MAX) begin
         return RAMP_T_MAX;
      end
      return t;
   endfunction

   // Pick a ramp time by its source method
   // External is no time source and falls back to the digital value
   function automatic logic [7:0] pick_time(input mrc_src_t src,
                                            input logic [7:0] dig);
      case (src)
         MRC_SRC_POT_ONE: pick_time = clamp_time(internal_pot_one_i);
         MRC_SRC_POT_TWO: pick_time = clamp_time(internal_pot_two_i);
         default:         pick_time = clamp_time(dig);
      endcase
   endfunction

   // Cycles between 1 r/min steps: time * tenth / 3000
   // Truncation makes a step up to one cycle early, so ramps run
   // a fraction of a percent fast rather than slow
   function automatic logic [31:0] step_cycles(input logic [7:0] t);
      logic [31:0] c;
      c = (32'(t) * 32'(TENTH_CYC)) / 32'(REF_SPEED_RPM);
      return (c == 32'h0) ? 32'h1 : c;
   endfunction

   // Method of the selected set from a method word, two bits a set
   function automatic mrc_src_t src_of(input logic [15:0] word,
                                       input logic [2:0] idx);
      return mrc_src_t'(word[2*idx +: 2]);
   endfunction

   // Ramp time of the selected set from a digital time word
   function automatic logic [7:0] byte_of(input logic [63:0] word,
                                          input logic [2:0] idx);
      return word[8*idx +: 8];
   endfunction

   // Reset record; ramp idle, peak torque until terminals settle
   localparam mrc_regs_t REGS_RST = '{
      run_s1: 2'h0,
      run_s2: 2'h0,
      dir_s: 2'h0,
      sel_s1: 3'h0,
      sel_s2: 3'h0,
      tl_s1: 3'h0,
      tl_s2: 3'h0,
      state: MRC_STOPPED,
      speed: 13'h0000,
      target: 13'h0000,
      tick_cnt: 32'h0,
      sel: 3'h0,
      speed_src: 16'h0000,
      torque_src: 16'h0000,
      accel_src: 16'h0000,
      decel_src: 16'h0000,
      shaft_cw: 1'b0,
      trq_cap: 8'h00,
      trq_peak: 1'b1,
      prohibited: 1'b0
   };

   // Synchronised terminal views
   logic [1:0] run_now;
   logic brake_on;
   logic run_on;
   logic dir_now;
   logic [2:0] sel_now;
   logic tl_on;
   logic [2:0] tl_eff;
   // Set point path
   logic [11:0] set_spd;
   logic [13:0] spd_sum;
   logic [11:0] offs;
   // Ramp path
   logic [7:0] acc_t;
   logic [7:0] dec_t;
   logic [31:0] step_lim;
   logic ramp_up;
   logic at_rest;
   // Method decode
   logic conflict;
   mrc_src_t s_src;
   mrc_src_t t_src;
   logic [7:0] trq_raw;

   // Next-state logic of the whole block
   // States: stopped idles; run ramps to the set point; decel
   // ramps to zero and then stops; instant clears the command in
   // one cycle and stops on the next
   always_comb begin
      r_d = r_q;
      // Two-flop synchronisers on every terminal; levels are held
      // by the controller for the recognition time
      r_d.run_s1 = {brake_release_input_i, run_request_input_i};
      r_d.run_s2 = r_q.run_s1;
      r_d.dir_s = {r_q.dir_s[0], direction_input_i};
      r_d.sel_s1 = {speed_select_bit2_i, speed_select_bit1_i,
                    speed_select_bit0_i};
      r_d.sel_s2 = r_q.sel_s1;
      r_d.tl_s1 = torque_limit_enable_input_i;
      r_d.tl_s2 = r_q.tl_s1;
      run_now = r_q.run_s2;
      brake_on = run_now[1];
      run_on = run_now[0];
      dir_now = r_q.dir_s[1];

      // Bit2 is off until it has a terminal
      sel_now = {r_q.sel_s2[2] & speed_select_bit2_assigned_i,
                 r_q.sel_s2[1], r_q.sel_s2[0]};

      // Unassigned terminals count as on; all assigned must be on
      tl_eff = r_q.tl_s2 | ~torque_limit_assigned_i;
      tl_on = &tl_eff;

      // Methods are latched only at standstill
      if (r_q.state == MRC_STOPPED) begin
         r_d.speed_src = set_speed_src_i;
         r_d.torque_src = set_torque_src_i;
         r_d.accel_src = set_accel_src_i;
         r_d.decel_src = set_decel_src_i;
      end
      r_d.sel = sel_now;

      s_src = src_of(r_q.speed_src, sel_now);
      t_src = src_of(r_q.torque_src, sel_now);
      // Same non-digital source on speed and torque is a conflict
      conflict = (s_src == t_src) && (s_src != MRC_SRC_DIGITAL);

      // Speed set point by source, analog path gets the offset
      // The offset only raises speed; larger requests saturate
      offs = (analog_offset_rpm_i > OFFSET_MAX_RPM) ?
             OFFSET_MAX_RPM : analog_offset_rpm_i;
      case (s_src)
         MRC_SRC_POT_ONE: set_spd = {internal_pot_one_i, 4'h0};
         MRC_SRC_POT_TWO: set_spd = {internal_pot_two_i, 4'h0};
         MRC_SRC_EXTERNAL: set_spd = analog_speed_rpm_i;
         default: set_spd = set_speed_rpm_i[12*sel_now +: 12];
      endcase
      spd_sum = {2'b00, set_spd};
      if (s_src == MRC_SRC_EXTERNAL) begin
         spd_sum = spd_sum + {2'b00, offs};
      end

      acc_t = pick_time(src_of(r_q.accel_src, sel_now),
                        byte_of(set_accel_digital_i, sel_now));
      dec_t = pick_time(src_of(r_q.decel_src, sel_now),
                        byte_of(set_decel_digital_i, sel_now));

      // Three-wire decode; brake release checked first
      // The flag is a level that drops once run is withdrawn
      r_d.prohibited = 1'b0;
      if (!brake_on) begin
         r_d.state = MRC_INSTANT;
      end else if (!run_on) begin
         if (r_q.state != MRC_INSTANT && r_q.state != MRC_STOPPED) begin
            r_d.state = MRC_DECEL;
         end
      end else if (conflict) begin
         r_d.prohibited = 1'b1;
         if (r_q.state == MRC_RUN) begin
            r_d.state = MRC_DECEL;
         end
      end else begin
         r_d.state = MRC_RUN;
      end
      // A stop that finds the command at rest goes straight to
      // stopped, so a stop at standstill never shows instant
      at_rest = (r_q.speed == 13'h0000);
      if ((r_d.state == MRC_INSTANT || r_d.state == MRC_DECEL) &&
          at_rest) begin
         r_d.state = MRC_STOPPED;
      end

      // Target speed, saturated to the command width
      // Any stop drives the target to zero, so decel reuses the ramp
      r_d.target = (r_d.state == MRC_RUN) ?
                   ((spd_sum > {1'b0, SPEED_MAX}) ? SPEED_MAX :
                    spd_sum[12:0]) : 13'h0000;

      // Linear ramp, 1 r/min per step at 3000 / time slope
      // The step counter restarts on each step but is compared with the live limit, so a new ramp time
      // takes hold within the current step
      ramp_up = (r_q.speed < r_q.target);
      step_lim = ramp_up ? step_cycles(acc_t)
                         : step_cycles(dec_t);
      if (r_q.state == MRC_INSTANT) begin
         r_d.speed = 13'h0000;
         r_d.tick_cnt = 32'h0;
      end else if (r_q.speed == r_q.target) begin
         r_d.tick_cnt = 32'h0;
      end else if (r_q.tick_cnt + 32'h1 >= step_lim) begin
         r_d.tick_cnt = 32'h0;
         r_d.speed = ramp_up ? r_q.speed + 13'h0001
                             : r_q.speed - 13'h0001;
      end else begin
         r_d.tick_cnt = r_q.tick_cnt + 32'h1;
      end

      // Direction sense from the rotation parameter
      r_d.shaft_cw = dir_now ~^ rotation_direction_cw_i;

      // Torque cap by source, clamped to 200 percent
      // The cap stays current even while the enable selects peak
      case (t_src)
         MRC_SRC_POT_ONE: trq_raw = internal_pot_one_i;
         MRC_SRC_POT_TWO: trq_raw = internal_pot_two_i;
         default: trq_raw = torque_limit_pct_i;
      endcase
      r_d.trq_cap = (trq_raw > TRQ_MAX_PCT) ? TRQ_MAX_PCT : trq_raw;
      r_d.trq_peak = ~tl_on;
   end

   // Single state register
   // Only constants in the reset branch, so the reset stays clean
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_q <= REGS_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the record
   // No logic after the flops, so the outputs never glitch
   assign command_speed_rpm_o = r_q.speed;
   assign shaft_cw_o = r_q.shaft_cw;
   assign torque_cap_pct_o = r_q.trq_cap;
   assign torque_peak_o = r_q.trq_peak;
   assign selected_set_o = r_q.sel;
   assign motor_state_o = r_q.state;
   assign operation_prohibited_flag_o = r_q.prohibited;

endmodule // mrc_run_logic

`default_nettype wire

// >>> tb/mrc_run_logic_assertions.sv
// Concurrent checks on the ports of the run command logic
`timescale 1ns/1ps
`default_nettype none
module mrc_run_logic_checker
   import mrc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic run_request_input_i,
   input wire logic brake_release_input_i,
   input wire logic speed_select_bit0_i,
   input wire logic speed_select_bit1_i,
   input wire logic speed_select_bit2_i,
   input wire logic speed_select_bit2_assigned_i,
   input wire logic [2:0] torque_limit_enable_input_i,
   input wire logic [2:0] torque_limit_assigned_i,
   input wire logic [12:0] command_speed_rpm_o,
   input wire logic [7:0] torque_cap_pct_o,
   input wire logic torque_peak_o,
   input wire logic [2:0] selected_set_o,
   input wire logic [1:0] motor_state_o,
   input wire logic operation_prohibited_flag_o
);
   // Raw terminal views; unassigned pins read as off or as on
   wire logic [2:0] sel_in = {speed_select_bit2_i
      & speed_select_bit2_assigned_i, speed_select_bit1_i,
      speed_select_bit0_i};
   wire logic lim_on = &(torque_limit_enable_input_i
      | ~torque_limit_assigned_i);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Terminal events; sync delay is three edges
   sequence run_held;
      (run_request_input_i && brake_release_input_i) [*5];
   endsequence
   sequence run_drop;
      $fell(run_request_input_i) && brake_release_input_i
         && motor_state_o == MRC_RUN;
   endsequence
   sequence brake_drop;
      $fell(brake_release_input_i)
         && (motor_state_o == MRC_RUN || motor_state_o == MRC_DECEL);
   endsequence
   chk_run_start: assert property (run_held |->
      motor_state_o == MRC_RUN || operation_prohibited_flag_o)
      else $error("run not entered");
   chk_decel_start: assert property (run_drop |->
      ##[2:4] motor_state_o == MRC_DECEL) else $error("no decel");
   chk_brake_wins: assert property (brake_drop |->
      ##[2:4] motor_state_o == MRC_INSTANT) else $error("no instant");
   chk_instant_zero: assert property (motor_state_o == MRC_INSTANT
      |=> command_speed_rpm_o == 13'h0000) else $error("speed kept");
   chk_instant_ends: assert property (motor_state_o == MRC_INSTANT
      |-> ##[1:3] motor_state_o == MRC_STOPPED) else $error("no stop");
   chk_accel_slope: assert property (motor_state_o == MRC_RUN
      |=> {1'b0, command_speed_rpm_o}
         <= {1'b0, $past(command_speed_rpm_o)} + 14'h0001)
      else $error("ramp too steep");
   chk_decel_slope: assert property (motor_state_o == MRC_DECEL
      |=> command_speed_rpm_o <= $past(command_speed_rpm_o))
      else $error("speed rose in decel");
   chk_select_map: assert property ($stable(sel_in) [*5]
      |-> selected_set_o == sel_in) else $error("wrong set");
   chk_limit_gate: assert property ($stable(lim_on) [*5]
      |-> torque_peak_o == !lim_on) else $error("limit gate wrong");
   chk_cap_range: assert property (torque_cap_pct_o <= TRQ_MAX_PCT)
      else $error("cap above range");
endmodule // mrc_run_logic_checker
bind mrc_run_logic mrc_run_logic_checker i_chk (.*);
`default_nettype wire

// >>> tb/mrc_ctrl_model.sv
// External controller driving the run and brake terminals
`timescale 1ns/1ps
`default_nettype none
module mrc_ctrl_model #(
   parameter int HOLD = 20
) (
   input wire logic clock_i,
   input wire logic [1:0] want_i,
   output var logic [1:0] term_o
);
   int held = 0;
   // A level moves only once the previous one stood long enough;
   // the hold is scaled down to keep the run short
   always @(negedge clock_i) begin
      if (want_i != term_o && held >= HOLD) begin
         term_o <= want_i;
         held <= 0;
      end else if (held < HOLD) begin
         held <= held + 1;
      end
   end
   initial term_o = 2'h0;
endmodule // mrc_ctrl_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the run command logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mrc_pkg::*;
   logic clock_i = 0, rst_n_i = 0, run_request_input_i, brake_release_input_i;
   logic direction_input_i = 0, speed_select_bit0_i = 0;
   logic speed_select_bit1_i = 0, speed_select_bit2_i = 0;
   logic speed_select_bit2_assigned_i = 0, rotation_direction_cw_i = 0;
   logic [2:0] torque_limit_enable_input_i = 0, torque_limit_assigned_i = 0;
   logic [11:0] analog_offset_rpm_i = 12'h000, analog_speed_rpm_i = 12'h000;
   logic [7:0] internal_pot_one_i = 8'h10, internal_pot_two_i = 8'h01;
   logic [7:0] torque_limit_pct_i = 8'h64;
   logic [95:0] set_speed_rpm_i = {8{12'h064}};
   logic [63:0] set_accel_digital_i = {8{8'h01}};
   logic [63:0] set_decel_digital_i = {8{8'h01}};
   logic [15:0] set_speed_src_i = 0, set_torque_src_i = 0;
   logic [15:0] set_accel_src_i = 0, set_decel_src_i = 0;
   logic [12:0] command_speed_rpm_o;
   logic [7:0] torque_cap_pct_o;
   logic [2:0] selected_set_o;
   logic [1:0] motor_state_o, want = 2'h0;
   logic shaft_cw_o, torque_peak_o, operation_prohibited_flag_o;
   int miscompares = 0, comparisons = 0;
   mrc_run_logic i_dut (.*);
   mrc_ctrl_model #(.HOLD(20)) i_ctrl (.clock_i(clock_i), .want_i(want),
      .term_o({run_request_input_i, brake_release_input_i}));
   // 20 MHz clock
   initial forever #25 clock_i = ~clock_i;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Bounded wait for a state; a miss ends the run
   task automatic wait_state(input logic [1:0] s);
      for (int n = 0; n < 200 && motor_state_o !== s; n++)
         @(negedge clock_i);
      chk({14'h0000, motor_state_o}, {14'h0000, s});
      if (motor_state_o !== s) close_out();
   endtask
   task automatic t_run_decel;
      want = 2'h3;
      wait_state(MRC_RUN);
      repeat (2000) @(negedge clock_i);
      chk({15'h0000, command_speed_rpm_o >= 13'h0002
         && command_speed_rpm_o <= 13'h0003}, 16'h0001);
      want = 2'h1;
      wait_state(MRC_DECEL);
      want = 2'h0;
      wait_state(MRC_INSTANT);
      @(negedge clock_i);
      chk({3'h0, command_speed_rpm_o}, 16'h0000);
      wait_state(MRC_STOPPED);
   endtask
   task automatic t_both_off;
      rotation_direction_cw_i = 1;
      direction_input_i = 1;
      want = 2'h3;
      wait_state(MRC_RUN);
      repeat (700) @(negedge clock_i);
      chk({15'h0000, shaft_cw_o}, 16'h0001);
      chk({3'h0, command_speed_rpm_o}, 16'h0001);
      want = 2'h0;
      wait_state(MRC_INSTANT);
      wait_state(MRC_STOPPED);
      direction_input_i = 0;
      repeat (25) @(negedge clock_i);
      chk({15'h0000, shaft_cw_o}, 16'h0000);
   endtask
   task automatic t_select;
      speed_select_bit2_assigned_i = 1;
      for (int i = 0; i < 8; i++) begin
         {speed_select_bit2_i, speed_select_bit1_i, speed_select_bit0_i}
            = 3'(i);
         repeat (25) @(negedge clock_i);
         chk({13'h0000, selected_set_o}, 16'(i));
      end
      speed_select_bit2_assigned_i = 0;
      repeat (25) @(negedge clock_i);
      chk({13'h0000, selected_set_o}, 16'h0003);
   endtask
   task automatic t_torque;
      logic [2:0] asg [4] = '{3'h0, 3'h3, 3'h3, 3'h7};
      logic [2:0] en [4] = '{3'h0, 3'h1, 3'h3, 3'h3};
      torque_limit_pct_i = 8'hFF;
      for (int k = 0; k < 4; k++) begin
         torque_limit_assigned_i = asg[k];
         torque_limit_enable_input_i = en[k];
         repeat (25) @(negedge clock_i);
         chk({15'h0000, torque_peak_o}, 16'(k[0]));
         if (k[0] == 0)
            chk({8'h00, torque_cap_pct_o}, 16'h00C8);
      end
   endtask
   task automatic t_conflict;
      {speed_select_bit2_i, speed_select_bit1_i, speed_select_bit0_i} = 0;
      set_speed_src_i = 16'h0001;
      set_torque_src_i = 16'h0001;
      want = 2'h3;
      repeat (30) @(negedge clock_i);
      chk({15'h0000, operation_prohibited_flag_o}, 16'h0001);
      want = 2'h0;
      repeat (25) @(negedge clock_i);
      wait_state(MRC_STOPPED);
      set_speed_src_i = 16'h0000;
      set_torque_src_i = 16'h0000;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(negedge clock_i);
      rst_n_i = 1;
      chk({3'h0, command_speed_rpm_o}, 16'h0000);
      chk({14'h0000, motor_state_o}, 16'h0000);
      chk({15'h0000, torque_peak_o}, 16'h0001);
      t_run_decel();
      t_both_off();
      t_select();
      t_torque();
      t_conflict();
      close_out();
   end
   // Hang guard
   initial begin
      repeat (90000) @(posedge clock_i);
      miscompares++;
      close_out();
   end
endmodule // testbench
`default_nettype wire
